// [hdl/bio_port.sv]
// Bidirectional I/O port: direction register, latch, pins and bit manage
module bio_port
  import bio_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [BIO_WIDTH-1:0] od_sel_i,
  input wire logic dir_we_i,
  input wire logic [BIO_WIDTH-1:0] dir_wdata_i,
  input wire logic dir_re_i,
  input wire logic data_we_i,
  input wire logic [BIO_WIDTH-1:0] data_wdata_i,
  input wire logic data_re_i,
  input wire logic bit_req_i,
  input wire logic [1:0] bit_op_i,
  input wire logic [2:0] bit_idx_i,
  output logic bit_busy_o,
  output logic [BIO_WIDTH-1:0] rdata_o,
  output logic rvalid_o,
  input wire logic [BIO_WIDTH-1:0] pin_i,
  output logic [BIO_WIDTH-1:0] pin_o,
  output logic [BIO_WIDTH-1:0] pin_oe_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [BIO_WIDTH-1:0] dir_r; // Direction, 1 drives
  logic [BIO_WIDTH-1:0] dir_nxt;
  logic [BIO_WIDTH-1:0] latch_r; // Port latch
  logic [BIO_WIDTH-1:0] latch_nxt;
  logic [BIO_WIDTH-1:0] rmw_r; // Byte captured by the read phase
  logic [BIO_WIDTH-1:0] od_r; // Registered open-drain select
  logic [1:0] op_r; // Pending bit operation
  logic [2:0] idx_r; // Pending bit index
  bio_state_e state_r;
  bio_state_e state_nxt;
  logic [BIO_WIDTH-1:0] pin_s; // Synchronised pin levels
  logic [BIO_WIDTH-1:0] port_view; // What a byte read sees
  logic [BIO_WIDTH-1:0] rmw_mod; // Captured byte after bit change
  logic [BIO_WIDTH-1:0] oe_nxt;
  logic [BIO_WIDTH-1:0] bit_mask;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  bio_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .async_i(pin_i),
    .sync_o(pin_s)
  );

  // ----------------------------------------------------------------
  // Read view and drive decode
  // ----------------------------------------------------------------
  // Mux per bit: pin for inputs, latch for outputs
  genvar g;
  generate
    for (g = 0; g < BIO_WIDTH; g++)
    begin : g_bit
      assign port_view[g] = dir_r[g] ? latch_r[g] : pin_s[g];
      // Driver on only when output; open-drain also needs latch low
      assign oe_nxt[g] = dir_r[g] & ~(od_r[g] & latch_r[g]);
    end
  endgenerate

  assign bit_mask = 8'h01 << idx_r;
  // Whole captured byte written back, inputs included
  assign rmw_mod = (op_r == BIO_OP_SET) ? (rmw_r | bit_mask) :
                   (op_r == BIO_OP_CLR) ? (rmw_r & ~bit_mask) : rmw_r;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Plain write only; a read of the direction address returns zeros, not the direction byte
  assign dir_nxt = dir_we_i ? dir_wdata_i : dir_r;

  // Direction changes never touch the latch
  always_comb
  begin
    latch_nxt = latch_r;
    state_nxt = state_r;
    case (state_r)
      BIO_IDLE:
      begin
        if (bit_req_i)
        begin
          state_nxt = BIO_READ;
        end
        else if (data_we_i)
        begin
          latch_nxt = data_wdata_i;
        end
      end
      BIO_READ:
      begin
        state_nxt = BIO_WRITE;
      end
      BIO_WRITE:
      begin
        latch_nxt = rmw_mod;
        state_nxt = BIO_IDLE;
      end
      default:
      begin
        state_nxt = BIO_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Direction and latch; reset leaves every pin an input
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      dir_r <= BIO_DIR_RST;
      latch_r <= BIO_LATCH_RST;
      state_r <= BIO_IDLE;
      od_r <= BIO_OD_RST;
    end
    else
    begin
      dir_r <= dir_nxt;
      latch_r <= latch_nxt;
      state_r <= state_nxt;
      od_r <= od_sel_i;
    end
  end

  // Operation capture and read phase of bit manage
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      op_r <= 2'h0;
      idx_r <= 3'h0;
      rmw_r <= BIO_RDATA_RST;
    end
    else if (state_r == BIO_IDLE && bit_req_i)
    begin
      op_r <= bit_op_i;
      idx_r <= bit_idx_i;
    end
    else if (state_r == BIO_READ)
    begin
      rmw_r <= port_view;
    end
  end

  // Read answers; direction address returns zeros, not its contents
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= BIO_RDATA_RST;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= data_re_i | dir_re_i;
      if (data_re_i)
      begin
        rdata_o <= port_view;
      end
      else if (dir_re_i)
      begin
        rdata_o <= BIO_RDATA_RST;
      end
    end
  end

  // Pin drive registers; one cycle behind latch and direction
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      pin_o <= 8'h00;
      pin_oe_o <= 8'h00;
      bit_busy_o <= 1'b0;
    end
    else
    begin
      pin_o <= latch_r & ~od_r; // Open-drain never drives high
      pin_oe_o <= oe_nxt;
      bit_busy_o <= (state_nxt != BIO_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  dir_hidden_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    dir_re_i && !data_re_i |=> rdata_o == 8'h00) else $error("direction readback leaked");
  input_off_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ((pin_oe_o & ~$past(dir_r)) == 8'h00)) else $error("input pin driven");
  od_float_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ((pin_oe_o & $past(od_r) & $past(latch_r)) == 8'h00)) else $error("open drain one driven");
  read_mix_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    data_re_i |=> rdata_o == (($past(dir_r) & $past(latch_r)) | (~$past(dir_r) & $past(pin_s))))
    else $error("port read value wrong");
  latch_keep_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    dir_we_i && !data_we_i && state_r == BIO_IDLE && !bit_req_i |=> $stable(latch_r))
    else $error("latch changed on direction write");
  rmw_seq_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    state_r == BIO_IDLE && bit_req_i && bit_op_i == BIO_OP_SET |-> ##2 state_r == BIO_WRITE ##1
    latch_r[$past(idx_r)] == 1'b1) else $error("bit set not applied");
  dir_map_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    dir_we_i |=> ##1 ((pin_oe_o & ~$past(dir_wdata_i, 2)) == 8'h00)) else $error("direction map wrong");
  reset_in_a: assert property (@(posedge clk_sys_i)
    !resetn_i |=> pin_oe_o == 8'h00 && dir_r == 8'h00) else $error("pin not input after reset");
  bit_cov: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    state_r == BIO_WRITE && op_r == BIO_OP_CLR);
  drive_cov: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) pin_oe_o != 8'h00);
  mix_cov: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
    data_re_i && dir_r != 8'h00 && dir_r != 8'hff);
endmodule

// [hdl/bio_pkg.sv]
// Package of constants for the bidirectional I/O port
package bio_pkg;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int BIO_WIDTH = 8; // One byte-wide port
  localparam logic [7:0] BIO_DIR_RST = 8'h00; // All pins input after reset
  localparam logic [7:0] BIO_LATCH_RST = 8'h00; // Latch cleared at reset
  localparam logic [7:0] BIO_RDATA_RST = 8'h00; // Read data idle value
  localparam logic [7:0] BIO_OD_RST = 8'h00; // Push-pull by default
  // ----------------------------------------------------------------
  // Bit-manage operation codes
  // ----------------------------------------------------------------
  localparam logic [1:0] BIO_OP_SET = 2'h1; // Set one bit
  localparam logic [1:0] BIO_OP_CLR = 2'h2; // Clear one bit
  // ----------------------------------------------------------------
  // Sequencer states, Gray coded from IDLE to WRITE; the return to IDLE flips both bits
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BIO_IDLE = 2'b00,
    BIO_READ = 2'b01,
    BIO_WRITE = 2'b11
  } bio_state_e;
endpackage

// [hdl/bio_sync.sv]
// Two-stage synchroniser for the port pin inputs
module bio_sync
  import bio_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [BIO_WIDTH-1:0] async_i,
  output logic [BIO_WIDTH-1:0] sync_o
);
  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  logic [BIO_WIDTH-1:0] meta_r; // First stage, read only by second

  // Both stages per bit; pins are independent so no gray needed
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// [sim/bio_ext_model.sv]
// Model of the external circuitry hung on the port pins
module bio_ext_model
(
  input wire logic [7:0] drv_i,
  input wire logic [7:0] drv_oe_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Port driver first, then outside drive, else the pull-up resistor,
  // so a released pin never shows a stale value
  assign level_o = (drv_oe_i & drv_i) | (~drv_oe_i & ((ext_en_i & ext_val_i) | ~ext_en_i));
endmodule

// [sim/testbench.sv]
// Self-checking testbench for the bidirectional I/O port
module testbench
  import bio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic dir_we = 1'b0, dir_re = 1'b0, data_we = 1'b0, data_re = 1'b0, bit_req = 1'b0;
  logic [7:0] od = 8'h00, dir_wd = 8'h00, dat_wd = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [1:0] op = 2'h0;
  logic [2:0] idx = 3'h0;
  logic busy, rvalid;
  logic [7:0] rdata, pin_o, pin_oe, pin_lv, d, l, e, x;
  int seed = 3;
  int n_mismatch = 0;
  int n_compared = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  bio_port dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .od_sel_i(od), .dir_we_i(dir_we),
    .dir_wdata_i(dir_wd), .dir_re_i(dir_re), .data_we_i(data_we), .data_wdata_i(dat_wd),
    .data_re_i(data_re), .bit_req_i(bit_req), .bit_op_i(op), .bit_idx_i(idx), .bit_busy_o(busy),
    .rdata_o(rdata), .rvalid_o(rvalid), .pin_i(pin_lv), .pin_o(pin_o), .pin_oe_o(pin_oe));
  bio_ext_model ext_u (.drv_i(pin_o), .drv_oe_i(pin_oe), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .level_o(pin_lv));
  // ----------------------------------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Plain store only, never read-modify-write on direction
  task automatic wr(input logic sel_dir, input logic [7:0] val);
    @(posedge clk_sys_i);
    dir_we <= sel_dir;
    data_we <= ~sel_dir;
    dir_wd <= val;
    dat_wd <= val;
    @(posedge clk_sys_i);
    dir_we <= 1'b0;
    data_we <= 1'b0;
    repeat (3) @(posedge clk_sys_i); // Pins one edge, synchroniser two more
  endtask
  task automatic rd(input logic sel_dir);
    @(posedge clk_sys_i);
    dir_re <= sel_dir;
    data_re <= ~sel_dir;
    @(posedge clk_sys_i);
    dir_re <= 1'b0;
    data_re <= 1'b0;
    @(negedge clk_sys_i); // Answer stands for this one cycle only
    check({7'h00, rvalid}, 8'h01);
  endtask
  // Input bits see the pin, output bits the latch
  function automatic logic [7:0] view_f(input logic [7:0] dd, ll, en, vv);
    return (dd & ll) | (~dd & ((en & vv) | ~en));
  endfunction
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence: random bytes with all-open-drain corners first
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    check(pin_oe, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      d = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      l = 8'($random(seed));
      @(posedge clk_sys_i);
      od <= (i < 2) ? 8'hff : 8'($random(seed));
      ext_en <= 8'($random(seed));
      ext_val <= 8'($random(seed));
      op <= i[1:0];
      idx <= 3'($random(seed));
      wr(1'b0, l);
      wr(1'b1, d);
      e = d & ~(od & l);
      check(pin_oe, e);
      check(pin_o & e, l & ~od & e);
      rd(1'b0);
      check(rdata, view_f(d, l, ext_en, ext_val));
      rd(1'b1);
      check(rdata, 8'h00);
      wr(1'b1, 8'hff);
      rd(1'b0);
      check(rdata, l);
      wr(1'b1, d);
      x = view_f(d, l, ext_en, ext_val);
      x = (op == BIO_OP_SET) ? x | (8'h01 << idx) : (op == BIO_OP_CLR) ? x & ~(8'h01 << idx) : x;
      @(posedge clk_sys_i);
      bit_req <= 1'b1;
      @(posedge clk_sys_i);
      bit_req <= 1'b0;
      @(negedge clk_sys_i); // Busy seen mid-cycle, clear of the launching edge
      check({7'h00, busy}, 8'h01);
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      check({7'h00, busy}, 8'h00);
      repeat (2) @(posedge clk_sys_i); // Latch settled before the next write
      wr(1'b1, 8'hff);
      rd(1'b0);
      check(rdata, x);
      $display("test %0d done", i);
    end
    // Reset in mid-run with every pin set to output: all fall back to input
    wr(1'b1, 8'hff);
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check(pin_oe, 8'h00);
    rd(1'b0);
    check(rdata, view_f(8'h00, 8'h00, ext_en, ext_val));
    wr(1'b1, 8'hff);
    rd(1'b0);
    check(rdata, 8'h00);
    $display("test mid-run reset done");
    end_sim;
  end
  // Watchdog well past the expected run length
  initial
  begin
    #200000;
    n_mismatch++;
    end_sim;
  end
endmodule
